//--- arp_ref_pair_ctrl.sv
// reference wake-up sequencing and channel-pair mode setup
// assumes serial pins are asynchronous to clk_sys; sclk much slower than clk_sys
//
// Overview of operation
// - temperature request, external clock mode: reference on, wait 244
// - temperature result out 188 cycles later
// - internal adc reference default; off after scan
// - reference off, analog conversion, external clock mode: wait 218
// - external reference selections, analog conversion: no wait, unused
// - route 00/01: no data, registers kept
// - route 10: next byte to unipolar register
// - route 11: next byte to bipolar register
// - unipolar bits 7..4 select pairs, rest ignored
// - bipolar bits 7..4 select pairs, rest ignored
// - both zero: pair is single-ended unipolar
// - both pair registers reset to zero
// - after route 00/01 next byte is command
`timescale 1ns/1ps
module arp_ref_pair_ctrl (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  input wire logic conv_req,
  input wire logic conv_is_temp,
  input wire logic scan_done,
  input wire logic [arp_pkg::TEMP_W-1:0] temp_result,
  output logic int_ref_on,
  output logic conv_start,
  output logic temp_ready,
  output logic [1:0] reference_source_select,
  output logic [1:0] clock_mode,
  output logic [3:0] pair_uni_diff,
  output logic [3:0] pair_bi_diff,
  output logic [3:0] pair_single_ended
);
  logic [2:0] cs_sync_q, sclk_sync_q, din_sync_q;
  logic [7:0] shift_q, shift_d;
  logic [2:0] bit_q;
  logic expect_q, target_bi_q;
  logic [3:0] uni_q, bi_q;
  logic [1:0] ref_sel_q, clk_mode_q;
  logic ref_on_q, ref_on_d;
  logic [7:0] cnt_q;
  logic wait_temp_q;
  logic [arp_pkg::TEMP_W-1:0] tx_q;
  arp_pkg::arp_state_t st_q, st_d;

  // stage 0 feeds stage 1 only; stages 1/2 give level and edge
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cs_sync_q <= 3'h7;
      sclk_sync_q <= 3'h0;
      din_sync_q <= 3'h0;
    end
    else
    begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      din_sync_q <= {din_sync_q[1:0], din};
    end
  end

  wire cs_act = !cs_sync_q[1];
  wire sclk_rise = sclk_sync_q[1] && !sclk_sync_q[2];
  wire sclk_fall = !sclk_sync_q[1] && sclk_sync_q[2];
  wire bit_take = cs_act && sclk_rise;
  wire byte_done = bit_take && (bit_q == arp_pkg::BIT_LAST);
  wire [7:0] rx_byte = {shift_q[6:0], din_sync_q[1]};
  wire is_setup = rx_byte[arp_pkg::SETUP_ID_MSB -: 2] == arp_pkg::SETUP_ID;
  wire [1:0] route = rx_byte[arp_pkg::ROUTE_MSB -: 2];
  wire data_byte = byte_done && expect_q;
  wire cmd_byte = byte_done && !expect_q;
  wire uni_wr = data_byte && !target_bi_q;
  wire bi_wr = data_byte && target_bi_q;
  assign shift_d = bit_take ? rx_byte : shift_q;

  // a frame of 16 clocks carries setup then data; select high aborts
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      expect_q <= 1'b0;
      target_bi_q <= 1'b0;
    end
    else if (!cs_act)
    begin
      bit_q <= 3'h0;
      expect_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      if (bit_take)
        bit_q <= bit_q + 3'h1;
      if (data_byte)
        expect_q <= 1'b0;
      else if (cmd_byte)
      begin
        expect_q <= is_setup && route[1];
        target_bi_q <= route[0];
      end
    end
  end

  // low nibble of data is dropped: only pair bits are kept
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      uni_q <= arp_pkg::PAIR_REG_RESET;
      bi_q <= arp_pkg::PAIR_REG_RESET;
      ref_sel_q <= arp_pkg::REF_SEL_RESET;
      clk_mode_q <= arp_pkg::CLK_MODE_RESET;
    end
    else
    begin
      if (uni_wr)
        uni_q <= rx_byte[7:4];
      if (bi_wr)
        bi_q <= rx_byte[7:4];
      if (cmd_byte && is_setup)
      begin
        ref_sel_q <= rx_byte[arp_pkg::REF_SEL_MSB -: 2];
        clk_mode_q <= rx_byte[arp_pkg::CLK_MODE_MSB -: 2];
      end
    end
  end

  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_pair
      assign pair_uni_diff[k] = uni_q[3-k];
      assign pair_bi_diff[k] = bi_q[3-k] && !uni_q[3-k];
      assign pair_single_ended[k] = !bi_q[3-k] && !uni_q[3-k];
    end
  endgenerate

  wire ext_mode = clk_mode_q == arp_pkg::CLK_MODE_EXT;
  wire ref_internal = (ref_sel_q == arp_pkg::REF_SEL_INT_BOTH) || (ref_sel_q == arp_pkg::REF_SEL_INT_ADC);
  wire start_req = (st_q == arp_pkg::ST_IDLE) && conv_req;
  wire ref_done = sclk_rise && (cnt_q == (wait_temp_q ? arp_pkg::REF_TEMP_CYC : arp_pkg::REF_AIN_CYC) - 8'h01);
  wire temp_done = sclk_rise && (cnt_q == arp_pkg::TEMP_OUT_CYC - 8'h01);

  // delays count external conversion clocks; other clock modes are out of scope and start at once
  always_comb
  begin
    st_d = st_q;
    ref_on_d = ref_on_q;
    conv_start = 1'b0;
    temp_ready = 1'b0;
    case (st_q)
      arp_pkg::ST_IDLE:
        if (conv_req && ext_mode && conv_is_temp)
        begin
          st_d = arp_pkg::ST_REF;
          ref_on_d = 1'b1;
        end
        else if (conv_req && ext_mode && ref_internal && !ref_on_q)
        begin
          st_d = arp_pkg::ST_REF;
          ref_on_d = 1'b1;
        end
        else if (conv_req)
        begin
          st_d = arp_pkg::ST_CONV;
          conv_start = 1'b1;
        end
      arp_pkg::ST_REF:
        if (ref_done && wait_temp_q)
          st_d = arp_pkg::ST_TEMP;
        else if (ref_done)
        begin
          st_d = arp_pkg::ST_CONV;
          conv_start = 1'b1;
        end
      arp_pkg::ST_TEMP:
        if (temp_done)
        begin
          st_d = arp_pkg::ST_IDLE;
          temp_ready = 1'b1;
          ref_on_d = ref_internal;
        end
      arp_pkg::ST_CONV:
        if (scan_done)
        begin
          st_d = arp_pkg::ST_IDLE;
          ref_on_d = 1'b0;
        end
      default:
        st_d = arp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= arp_pkg::ST_IDLE;
      ref_on_q <= 1'b0;
      cnt_q <= 8'h00;
      wait_temp_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      ref_on_q <= ref_on_d;
      if (st_d != st_q)
        cnt_q <= 8'h00;
      else if (sclk_rise)
        cnt_q <= cnt_q + 8'h01;
      if (start_req)
        wait_temp_q <= conv_is_temp;
    end
  end

  // result shifts out msb first on falling clock edges after it is ready
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      tx_q <= '0;
    else if (temp_ready)
      tx_q <= temp_result;
    else if (cs_act && sclk_fall)
      tx_q <= {tx_q[arp_pkg::TEMP_W-2:0], 1'b0};
  end

  assign dout = tx_q[arp_pkg::TEMP_W-1];
  assign int_ref_on = ref_on_q;
  assign reference_source_select = ref_sel_q;
  assign clock_mode = clk_mode_q;

  property p_temp_ref_on;
    @(posedge clk_sys) disable iff (!resetn)
    (st_q == arp_pkg::ST_TEMP) |-> ref_on_q;
  endproperty
  a_temp_ref_on: assert property (p_temp_ref_on) else $error("reference off during temperature wait");

  property p_temp_ref_len;
    @(posedge clk_sys) disable iff (!resetn)
    (st_q == arp_pkg::ST_REF && wait_temp_q && st_d != arp_pkg::ST_REF) |-> (cnt_q == 8'hf3 && sclk_rise);
  endproperty
  a_temp_ref_len: assert property (p_temp_ref_len) else $error("temperature reference wait not 244");

  property p_temp_hold;
    @(posedge clk_sys) disable iff (!resetn)
    (st_q == arp_pkg::ST_TEMP && !(sclk_rise && cnt_q == 8'hbb)) |=> (st_q == arp_pkg::ST_TEMP) && !$past(temp_ready);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("temperature result not at 188");

  property p_scan_off;
    @(posedge clk_sys) disable iff (!resetn)
    (st_q == arp_pkg::ST_CONV && scan_done) |=> !ref_on_q && st_q == arp_pkg::ST_IDLE;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("reference still on after scan");

  property p_ain_wake;
    @(posedge clk_sys) disable iff (!resetn)
    (start_req && ext_mode && !conv_is_temp && ref_internal && !ref_on_q) |=>
      st_q == arp_pkg::ST_REF ##0 !conv_start [*3];
  endproperty
  a_ain_wake: assert property (p_ain_wake) else $error("no wake-up delay for analog input");

  property p_ain_wake_len;
    @(posedge clk_sys) disable iff (!resetn)
    (st_q == arp_pkg::ST_REF && !wait_temp_q && conv_start) |-> cnt_q == 8'hd9;
  endproperty
  a_ain_wake_len: assert property (p_ain_wake_len) else $error("analog wake-up delay not 218");

  property p_ext_ref;
    @(posedge clk_sys) disable iff (!resetn)
    (start_req && !conv_is_temp && !ref_internal) |-> conv_start ##1 (st_q == arp_pkg::ST_CONV && $stable(ref_on_q));
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("external reference path delayed");

  property p_no_data;
    @(posedge clk_sys) disable iff (!resetn)
    (cmd_byte && !route[1]) |=> !expect_q && $stable(uni_q) && $stable(bi_q);
  endproperty
  a_no_data: assert property (p_no_data) else $error("route 00/01 expected data");

  property p_uni_wr;
    @(posedge clk_sys) disable iff (!resetn)
    uni_wr |=> uni_q == $past(rx_byte[7:4]) && $stable(bi_q) && !expect_q;
  endproperty
  a_uni_wr: assert property (p_uni_wr) else $error("unipolar register not written");

  property p_bi_wr;
    @(posedge clk_sys) disable iff (!resetn)
    bi_wr |=> bi_q == $past(rx_byte[7:4]) && $stable(uni_q);
  endproperty
  a_bi_wr: assert property (p_bi_wr) else $error("bipolar register not written");

  property p_uni_prio;
    @(posedge clk_sys) disable iff (!resetn)
    (|(uni_q & bi_q)) |-> (|pair_bi_diff) == (|(bi_q & ~uni_q)) && !(|(pair_bi_diff & pair_uni_diff));
  endproperty
  a_uni_prio: assert property (p_uni_prio) else $error("bipolar overrides unipolar");

  c_temp_done: cover property (@(posedge clk_sys) disable iff (!resetn) temp_ready);
  c_ain_wake: cover property (@(posedge clk_sys) disable iff (!resetn)
    st_q == arp_pkg::ST_REF && !wait_temp_q && conv_start);
  c_uni_wr: cover property (@(posedge clk_sys) disable iff (!resetn) uni_wr);
  c_bi_wr: cover property (@(posedge clk_sys) disable iff (!resetn) bi_wr);
endmodule

//--- arp_pkg.sv
// constants for the reference wake-up and pair-mode setup logic
// assumes one system clock; serial pins are sampled, not used as clocks
package arp_pkg;
  localparam logic [7:0] REF_TEMP_CYC = 8'hf4;
  localparam logic [7:0] TEMP_OUT_CYC = 8'hbc;
  localparam logic [7:0] REF_AIN_CYC = 8'hda;
  localparam logic [1:0] SETUP_ID = 2'h1;
  localparam int SETUP_ID_MSB = 7;
  localparam int CLK_MODE_MSB = 5;
  localparam int REF_SEL_MSB = 3;
  localparam int ROUTE_MSB = 1;
  localparam logic [1:0] CLK_MODE_EXT = 2'h3;
  localparam logic [1:0] CLK_MODE_RESET = 2'h0;
  localparam logic [1:0] REF_SEL_INT_BOTH = 2'h0;
  localparam logic [1:0] REF_SEL_EXT_SE = 2'h1;
  localparam logic [1:0] REF_SEL_INT_ADC = 2'h2;
  localparam logic [1:0] REF_SEL_EXT_DIFF = 2'h3;
  localparam logic [1:0] REF_SEL_RESET = REF_SEL_INT_ADC;
  localparam logic [3:0] PAIR_REG_RESET = 4'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int TEMP_W = 12;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REF = 4'b0010,
    ST_TEMP = 4'b0100,
    ST_CONV = 4'b1000
  } arp_state_t;
endpackage

//--- arp_host_model.sv
// serial host model: drives select, clock and data, collects dout
// assumes clk_sys at 20 MHz; one sclk period is eight clk_sys cycles
`timescale 1ns/1ps
module arp_host_model (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout
);
  logic [15:0] rx;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    rx = 16'h0000;
  end
  // 200 ns half period; dout is taken at the rising edge
  task automatic tick();
    repeat (4) @(negedge clk_sys);
    sclk = 1'b1;
    rx = {rx[14:0], dout};
    repeat (4) @(negedge clk_sys);
    sclk = 1'b0;
  endtask
  // conversion clock; it also runs with select high
  task automatic clocks(input int n);
    repeat (n) tick();
  endtask
  // msb first; setup and data byte share one select window
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic two);
    logic [15:0] w;
    w = {b0, b1};
    // a clock fall just made must not reach the block together with select low
    repeat (4) @(negedge clk_sys);
    cs_n = 1'b0;
    for (int i = 15; i >= (two ? 0 : 8); i--)
    begin
      din = w[i];
      tick();
    end
    repeat (4) @(negedge clk_sys);
    cs_n = 1'b1;
    // released line shows the inverse, never a stale level
    din = ~din;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

//--- adc_ref_and_pair_config_bench.sv
// bench for reference wake-up and pair-mode setup
// assumes arp_host_model as serial host; sclk is also the conversion clock
`timescale 1ns/1ps
module adc_ref_and_pair_config_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cs_n, sclk, din, dout;
  logic conv_req = 1'b0;
  logic conv_is_temp = 1'b0;
  logic scan_done = 1'b0;
  logic [arp_pkg::TEMP_W-1:0] temp_result = 12'h000;
  logic int_ref_on, conv_start, temp_ready;
  logic [1:0] ref_sel, clk_mode;
  logic [3:0] uni, bi, se;
  logic [15:0] cfg;
  int failures = 0;
  int n_checks = 0;
  int n_rise = 0;
  int seen_at = 0;
  assign cfg = {ref_sel, clk_mode, uni, bi, se};
  always #25 clk_sys = ~clk_sys;
  always @(posedge sclk) n_rise++;
  // pulses are read mid-cycle, once the falling-edge stimulus has settled
  always @(negedge clk_sys) #1 if (temp_ready === 1'b1 || conv_start === 1'b1) seen_at = n_rise;
  arp_host_model i_host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
  arp_ref_pair_ctrl i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .conv_req(conv_req), .conv_is_temp(conv_is_temp), .scan_done(scan_done),
    .temp_result(temp_result), .int_ref_on(int_ref_on), .conv_start(conv_start),
    .temp_ready(temp_ready), .reference_source_select(ref_sel), .clock_mode(clk_mode),
    .pair_uni_diff(uni), .pair_bi_diff(bi), .pair_single_ended(se)
  );
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // wait counted in sclk rises from the request to the pulse
  task automatic conv(input logic t, input logic r, input logic [15:0] exp, input int n);
    n_rise = 0;
    seen_at = -1;
    conv_is_temp = t;
    conv_req = 1'b1;
    @(negedge clk_sys);
    conv_req = 1'b0;
    @(negedge clk_sys);
    check("ref_on", {15'h0000, int_ref_on}, {15'h0000, r});
    i_host.clocks(n);
    check("wait", seen_at[15:0], exp);
  endtask
  task automatic end_scan();
    scan_done = 1'b1;
    @(negedge clk_sys);
    scan_done = 1'b0;
    @(negedge clk_sys);
    check("ref_off", {15'h0000, int_ref_on}, 16'h0000);
  endtask
  initial
  begin
    repeat (9) @(negedge clk_sys);
    check("cfg_reset", cfg, 16'h800f);
    check("dout_reset", {15'h0000, dout}, 16'h0000);
    @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    i_host.frame(8'h4a, 8'haf, 1'b1);
    check("cfg_uni", cfg, 16'h850a);
    i_host.frame(8'h4b, 8'hcf, 1'b1);
    check("cfg_bi", cfg, 16'h8528);
    for (int r = 0; r < 2; r++)
    begin
      // second byte must be read as a fresh setup command
      i_host.frame(8'h48 | 8'(r), 8'h75, 1'b1);
      check("cfg_route", cfg, 16'h7528);
    end
    for (int s = 0; s < 4; s++)
    begin
      temp_result = {10'h169, s[1:0]};
      i_host.frame({4'h7, s[1:0], 2'h0}, 8'h00, 1'b0);
      conv(1'b1, 1'b1, 16'd432, 440);
      i_host.frame(8'h00, 8'h00, 1'b1);
      check("temp", {i_host.rx[15:4], 4'h0}, {temp_result, 4'h0});
      check("ref_kept", {15'h0000, int_ref_on}, {15'h0000, ~s[0]});
      conv(1'b0, ~s[0], 16'd0, 4);
      end_scan();
      conv(1'b0, ~s[0], s[0] ? 16'd0 : 16'd218, 226);
      end_scan();
    end
    // clock mode 00: no wake-up delay even with the internal reference off
    i_host.frame(8'h48, 8'h00, 1'b0);
    conv(1'b0, 1'b0, 16'd0, 4);
    end_scan();
    complete_run();
  end
  // about 23000 clk_sys cycles expected
  initial
  begin
    #3000000;
    failures++;
    complete_run();
  end
endmodule
